// ==== logic/gas_module_serial_framer.sv ====
// nine-byte serial framer, mode control and indicator of the gas module
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module gas_module_serial_framer
  import gas_framer_pkg::*;
#(
  parameter logic [15:0] BIT_CYC      = BAUD_CYC,
  parameter logic [31:0] UPLOAD_LEN   = UPLOAD_CYC,
  parameter logic [31:0] QA_LEN       = QA_TIMEOUT_CYC,
  parameter logic [35:0] PREHEAT_LEN  = PREHEAT_CYC,
  parameter logic [31:0] SLOW_ON_LEN  = SLOW_ON_CYC,
  parameter logic [31:0] SLOW_OFF_LEN = SLOW_OFF_CYC,
  parameter logic [31:0] FAULT_ON_LEN = FAULT_ON_CYC,
  parameter logic [31:0] FAULT_OFF_LEN = FAULT_OFF_CYC,
  parameter logic [31:0] ALARM_ON_LEN = ALARM_ON_CYC,
  parameter logic [31:0] ALARM_OFF_LEN = ALARM_OFF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rxd,
  output logic             txd,
  output logic             led,
  output logic             irq
);
  typedef struct packed {
    logic             rx_meta;
    logic             rx_sync;
    logic             qa_mode;
    logic [31:0]      up_cnt;
    logic [31:0]      qa_cnt;
    logic [35:0]      pre_cnt;
    logic             pre_done;
    pat_t             pat;
    logic [31:0]      blink_cnt;
    logic             led;
    logic             up_pend;
    logic             resp_pend;
    logic [8:0][7:0]  tx_buf;
    logic [3:0]       tx_idx;
    logic             tx_busy;
    logic [8:0][7:0]  rx_buf;
    logic [3:0]       rx_idx;
    logic [15:0]      sensor;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } state_t;

  state_t          st;
  state_t          next_st;
  logic [3:0]      ev;
  logic            tx_ready;
  logic            rx_valid;
  logic [7:0]      rx_data;

  // serial line at 9600 baud, 8N1
  uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .valid   (st.tx_busy),
    .data    (st.tx_buf[st.tx_idx]),
    .ready   (tx_ready),
    .txd     (txd)
  );

  uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rxd     (st.rx_sync),
    .valid   (rx_valid),
    .data    (rx_data)
  );

  assign awready = !st.aw_got && !st.bvalid;
  assign wready  = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;
  assign led     = st.led;
  assign irq     = |(st.irq_stat & st.irq_mask);

  always_comb begin
    logic [8:0][7:0] f;
    logic [3:0]      clr;
    pat_t            want;
    logic [31:0]     on_len;
    logic [31:0]     off_len;
    logic [7:0]      hi;
    next_st = st;
    ev      = 4'h0;
    clr     = 4'h0;
    f       = st.rx_buf;
    want    = PAT_OFF;
    hi      = 8'h00;
    on_len  = SLOW_ON_LEN;
    off_len = SLOW_OFF_LEN;
    next_st.rx_meta = rxd;
    next_st.rx_sync = st.rx_meta;

    // register bus: address and data taken in either order
    if (awvalid && awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      case (reg_decode(st.aw_addr))
        REG_SENSOR: begin
          for (int b = 0; b < 2; b++) begin
            if (st.w_strb[b]) begin
              next_st.sensor[8*b +: 8] = st.w_data[8*b +: 8];
            end
          end
        end
        REG_IRQ_STAT: clr = st.w_strb[0] ? st.w_data[3:0] : 4'h0;
        REG_IRQ_MASK: begin
          if (st.w_strb[0]) begin
            next_st.irq_mask = st.w_data[3:0];
          end
        end
        REG_STATUS: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_DECERR;
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      case (reg_decode(araddr))
        REG_SENSOR:   next_st.rdata = {16'h0000, st.sensor};
        REG_STATUS:   next_st.rdata = {28'h0000000, st.tx_busy, st.led,
                                       st.pre_done, st.qa_mode};
        REG_IRQ_STAT: next_st.rdata = {28'h0000000, st.irq_stat};
        REG_IRQ_MASK: next_st.rdata = {28'h0000000, st.irq_mask};
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = RESP_DECERR;
        end
      endcase
    end

    // periodic uploads run only in upload mode
    if (!st.qa_mode) begin
      if (st.up_cnt == UPLOAD_LEN - 32'h1) begin
        next_st.up_cnt  = 32'h0;
        next_st.up_pend = 1'b1;
      end else begin
        next_st.up_cnt = st.up_cnt + 32'h1;
      end
    end else begin
      next_st.up_cnt  = 32'h0;
      next_st.up_pend = 1'b0;
      if (st.qa_cnt == QA_LEN - 32'h1) begin
        next_st.qa_mode = 1'b0;
        ev[IRQ_REVERT]  = 1'b1;
      end else begin
        next_st.qa_cnt = st.qa_cnt + 32'h1;
      end
    end

    // receive: hunt for the start byte, then collect nine bytes
    if (rx_valid) begin
      if (st.rx_idx == 4'h0 && rx_data != START_BYTE) begin
        next_st.rx_idx = 4'h0;
      end else if (st.rx_idx == FRAME_LAST) begin
        f[8] = rx_data;
        next_st.rx_idx = 4'h0;
        // only a read command with a good sum is a query
        if (f[8] == frame_sum(f) && f[2] == CMD_READ) begin
          next_st.qa_mode   = 1'b1;
          next_st.qa_cnt    = 32'h0;
          next_st.resp_pend = 1'b1;
          // a waiting upload is dropped, the reply goes instead
          next_st.up_pend   = 1'b0;
          ev[IRQ_QUERY]     = 1'b1;
        end else begin
          ev[IRQ_DROP] = 1'b1;
        end
      end else begin
        next_st.rx_buf[st.rx_idx] = rx_data;
        next_st.rx_idx = st.rx_idx + 4'h1;
      end
    end

    // transmit: a reply outranks an upload
    if (st.tx_busy) begin
      if (tx_ready) begin
        if (st.tx_idx == FRAME_LAST) begin
          next_st.tx_busy = 1'b0;
          next_st.tx_idx  = 4'h0;
          ev[IRQ_SENT]    = 1'b1;
        end else begin
          next_st.tx_idx = st.tx_idx + 4'h1;
        end
      end
    end else if (st.resp_pend) begin
      // the alarm flag of the high byte is kept out of the reply, the fault flag stays in its top bit
      hi = {st.sensor[SENS_FAULT_BIT], 1'b0, st.sensor[13:8]};
      next_st.resp_pend = 1'b0;
      next_st.tx_busy   = 1'b1;
      next_st.tx_idx    = 4'h0;
      next_st.tx_buf    = {8'h00, st.sensor[7:0], hi, RESERVED, RESERVED,
                           st.sensor[7:0], hi, CMD_READ, START_BYTE};
      next_st.tx_buf[8] = frame_sum(next_st.tx_buf);
    end else if (st.up_pend && !st.qa_mode) begin
      hi = {st.sensor[SENS_FAULT_BIT], st.sensor[SENS_ALARM_BIT],
            st.sensor[13:8]};
      next_st.up_pend = 1'b0;
      next_st.tx_busy = 1'b1;
      next_st.tx_idx  = 4'h0;
      next_st.tx_buf  = {8'h00, RANGE_LO, RANGE_HI, st.sensor[7:0], hi,
                         DECIMALS, UNIT_PPM, GAS_METHANE,
                         START_BYTE};
      next_st.tx_buf[8] = frame_sum(next_st.tx_buf);
    end

    // indicator: fault outranks alarm outranks preheat
    if (!st.pre_done) begin
      if (st.pre_cnt == PREHEAT_LEN - 36'h1) begin
        next_st.pre_done = 1'b1;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 36'h1;
      end
    end
    if (st.sensor[SENS_FAULT_BIT]) begin
      want = PAT_FAULT;
    end else if (st.sensor[SENS_ALARM_BIT]) begin
      want = PAT_ALARM;
    end else if (!st.pre_done) begin
      want = PAT_SLOW;
    end else begin
      want = PAT_OFF;
    end
    case (st.pat)
      PAT_FAULT: begin
        on_len  = FAULT_ON_LEN;
        off_len = FAULT_OFF_LEN;
      end
      PAT_ALARM: begin
        on_len  = ALARM_ON_LEN;
        off_len = ALARM_OFF_LEN;
      end
      default: begin
        on_len  = SLOW_ON_LEN;
        off_len = SLOW_OFF_LEN;
      end
    endcase
    next_st.blink_cnt = st.blink_cnt + 32'h1;
    if (want != st.pat) begin
      // a new pattern other than off starts with a full on phase
      next_st.pat       = want;
      next_st.blink_cnt = 32'h0;
      next_st.led       = (want != PAT_OFF);
    end else if (st.pat == PAT_OFF) begin
      next_st.led       = 1'b0;
      next_st.blink_cnt = 32'h0;
    end else if (st.led && st.blink_cnt == on_len - 32'h1) begin
      next_st.led       = 1'b0;
      next_st.blink_cnt = 32'h0;
    end else if (!st.led && st.blink_cnt == off_len - 32'h1) begin
      next_st.led       = 1'b1;
      next_st.blink_cnt = 32'h0;
    end

    // an event in the clearing cycle survives
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.rx_meta  <= 1'b1;
      st.rx_sync  <= 1'b1;
      st.sensor   <= SENSOR_RST;
      st.irq_mask <= IRQ_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_frame_start: assert property ($rose(st.tx_busy) |->
    st.tx_buf[0] == START_BYTE && st.tx_idx == 4'h0)
    else $error("frame does not open with the start byte");
  a_frame_sum: assert property ($rose(st.tx_busy) |->
    st.tx_buf[8] == frame_sum(st.tx_buf))
    else $error("frame checksum wrong");
  a_gas_unit: assert property ($rose(st.tx_busy) && !st.qa_mode |->
    st.tx_buf[1] == GAS_METHANE && st.tx_buf[2] == UNIT_PPM)
    else $error("gas or unit byte wrong");
  a_fault_flag: assert property ($rose(st.tx_busy) |->
    st.tx_buf[st.qa_mode ? 2 : 4][7] == $past(st.sensor[SENS_FAULT_BIT]))
    else $error("fault flag not in top bit");
  a_alarm_flag: assert property ($rose(st.tx_busy) && !st.qa_mode |->
    st.tx_buf[4][6] == $past(st.sensor[SENS_ALARM_BIT]))
    else $error("alarm flag wrong");
  a_conc_value: assert property ($rose(st.tx_busy) && !st.qa_mode |->
    {st.tx_buf[4][5:0], st.tx_buf[5]} == $past(st.sensor[13:0]))
    else $error("concentration field wrong");
  a_full_range: assert property ($rose(st.tx_busy) && !st.qa_mode |->
    {st.tx_buf[6], st.tx_buf[7]} == {RANGE_HI, RANGE_LO})
    else $error("full range field wrong");
  a_reply_echo: assert property ($rose(st.tx_busy) && st.qa_mode |->
    st.tx_buf[1] == CMD_READ && st.tx_buf[6] == st.tx_buf[2]
    && st.tx_buf[7] == st.tx_buf[3])
    else $error("reply layout wrong");
  a_query_mode: assert property (ev[IRQ_QUERY] |=>
    st.qa_mode && st.resp_pend && !st.up_pend)
    else $error("query did not enter answer mode");
  a_no_upload: assert property (st.qa_mode |-> ##1 !st.up_pend)
    else $error("upload pending in answer mode");
  a_led_off: assert property (st.pat == PAT_OFF [*2] |-> !st.led)
    else $error("indicator lit after preheat");
endmodule // gas_module_serial_framer

// ==== logic/gas_framer_pkg.sv ====
// shared constants and types of the gas module serial framer
package gas_framer_pkg;
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint BAUD         = 9600;
  localparam longint UPLOAD_MS    = 500;
  localparam longint QA_TIMEOUT_S = 15;
  localparam longint PREHEAT_S    = 180;
  localparam longint SLOW_ON_MS   = 500;
  localparam longint SLOW_OFF_MS  = 500;
  localparam longint FAULT_ON_MS  = 75;
  localparam longint FAULT_OFF_MS = 175;
  localparam longint ALARM_ON_MS  = 25;
  localparam longint ALARM_OFF_MS = 75;

  localparam logic [15:0] BAUD_CYC      = 16'(CLK_HZ / BAUD);
  localparam logic [31:0] UPLOAD_CYC    = 32'(CLK_HZ / 1000 * UPLOAD_MS);
  localparam logic [31:0] QA_TIMEOUT_CYC = 32'(CLK_HZ * QA_TIMEOUT_S);
  localparam logic [35:0] PREHEAT_CYC   = 36'(CLK_HZ * PREHEAT_S);
  localparam logic [31:0] SLOW_ON_CYC   = 32'(CLK_HZ / 1000 * SLOW_ON_MS);
  localparam logic [31:0] SLOW_OFF_CYC  = 32'(CLK_HZ / 1000 * SLOW_OFF_MS);
  localparam logic [31:0] FAULT_ON_CYC  = 32'(CLK_HZ / 1000 * FAULT_ON_MS);
  localparam logic [31:0] FAULT_OFF_CYC = 32'(CLK_HZ / 1000 * FAULT_OFF_MS);
  localparam logic [31:0] ALARM_ON_CYC  = 32'(CLK_HZ / 1000 * ALARM_ON_MS);
  localparam logic [31:0] ALARM_OFF_CYC = 32'(CLK_HZ / 1000 * ALARM_OFF_MS);

  localparam logic [7:0] START_BYTE  = 8'hff;
  localparam logic [7:0] GAS_METHANE = 8'h01;
  localparam logic [7:0] UNIT_PPM    = 8'h03;
  localparam logic [7:0] DECIMALS    = 8'h00;
  localparam logic [7:0] RANGE_HI    = 8'h13;
  localparam logic [7:0] RANGE_LO    = 8'h88;
  localparam logic [7:0] CMD_READ    = 8'h86;
  localparam logic [7:0] RESERVED    = 8'h00;
  localparam logic [3:0] FRAME_LAST  = 4'h8;

  localparam logic [7:0] SENSOR_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam int SENS_FAULT_BIT = 15;
  localparam int SENS_ALARM_BIT = 14;
  localparam int IRQ_SENT   = 0;
  localparam int IRQ_QUERY  = 1;
  localparam int IRQ_DROP   = 2;
  localparam int IRQ_REVERT = 3;
  localparam logic [15:0] SENSOR_RST   = 16'h0000;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    PAT_OFF   = 2'b00,
    PAT_SLOW  = 2'b01,
    PAT_FAULT = 2'b10,
    PAT_ALARM = 2'b11
  } pat_t;

  typedef enum logic [2:0] {
    REG_SENSOR   = 3'b000,
    REG_STATUS   = 3'b001,
    REG_IRQ_STAT = 3'b010,
    REG_IRQ_MASK = 3'b011,
    REG_NONE     = 3'b100
  } reg_sel_t;

  // two's complement of the sum of bytes one to seven
  function automatic logic [7:0] frame_sum(input logic [8:0][7:0] f);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 1; i < 8; i++) begin
      s = s + f[i];
    end
    return 8'(~s + 8'h01);
  endfunction

  function automatic reg_sel_t reg_decode(input logic [7:0] a);
    case (a)
      SENSOR_OFS:   return REG_SENSOR;
      STATUS_OFS:   return REG_STATUS;
      IRQ_STAT_OFS: return REG_IRQ_STAT;
      IRQ_MASK_OFS: return REG_IRQ_MASK;
      default:      return REG_NONE;
    endcase
  endfunction
endpackage

// ==== logic/uart_tx.sv ====
// serial transmitter, 8 data bits, one stop bit, no parity
`timescale 1ns/10ps
module uart_tx
  import gas_framer_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = BAUD_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready,
  output logic            txd
);
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_ph_t;

  typedef struct packed {
    tx_ph_t      ph;
    logic [15:0] cnt;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        line;
  } tx_st_t;

  tx_st_t st;
  tx_st_t next_st;

  assign ready = (st.ph == TX_IDLE);
  assign txd   = st.line;

  always_comb begin
    next_st = st;
    next_st.cnt = st.cnt + 16'h0001;
    case (st.ph)
      TX_IDLE: begin
        next_st.cnt = 16'h0000;
        if (valid) begin
          next_st.sh   = data;
          next_st.ph   = TX_START;
          next_st.line = 1'b0;
        end
      end
      TX_START: begin
        if (st.cnt == BIT_CYC - 16'h0001) begin
          next_st.cnt  = 16'h0000;
          next_st.bitn = 3'h0;
          next_st.ph   = TX_DATA;
          next_st.line = st.sh[0];
        end
      end
      TX_DATA: begin
        if (st.cnt == BIT_CYC - 16'h0001) begin
          next_st.cnt = 16'h0000;
          next_st.sh  = {1'b0, st.sh[7:1]};
          if (st.bitn == 3'h7) begin
            next_st.ph   = TX_STOP;
            next_st.line = 1'b1;
          end else begin
            next_st.bitn = st.bitn + 3'h1;
            next_st.line = st.sh[1];
          end
        end
      end
      default: begin
        if (st.cnt == BIT_CYC - 16'h0001) begin
          next_st.ph = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= '0;
      st.line <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule // uart_tx

// ==== logic/uart_rx.sv ====
// serial receiver, 8 data bits, one stop bit, no parity
`timescale 1ns/10ps
module uart_rx
  import gas_framer_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = BAUD_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       rxd,
  output logic            valid,
  output logic [7:0]      data
);
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_ph_t;

  typedef struct packed {
    rx_ph_t      ph;
    logic [15:0] cnt;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        valid;
    logic [7:0]  data;
  } rx_st_t;

  rx_st_t st;
  rx_st_t next_st;

  assign valid = st.valid;
  assign data  = st.data;

  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.cnt   = st.cnt + 16'h0001;
    case (st.ph)
      RX_IDLE: begin
        next_st.cnt = 16'h0000;
        if (!rxd) begin
          next_st.ph = RX_START;
        end
      end
      RX_START: begin
        // mid start bit: a glitch shorter than half a bit is dropped
        if (st.cnt == (BIT_CYC >> 1)) begin
          next_st.cnt  = 16'h0000;
          next_st.bitn = 3'h0;
          next_st.ph   = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (st.cnt == BIT_CYC - 16'h0001) begin
          next_st.cnt = 16'h0000;
          next_st.sh  = {rxd, st.sh[7:1]};
          if (st.bitn == 3'h7) begin
            next_st.ph = RX_STOP;
          end else begin
            next_st.bitn = st.bitn + 3'h1;
          end
        end
      end
      default: begin
        // a missing stop bit loses the byte
        if (st.cnt == BIT_CYC - 16'h0001) begin
          next_st.ph    = RX_IDLE;
          next_st.valid = rxd;
          next_st.data  = rxd ? st.sh : st.data;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // uart_rx

// ==== testbench/host_link.sv ====
// host serial model: sends bytes, gathers device frames
`timescale 1ns/10ps
module host_link #(
  parameter int BIT = 16
) (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] q[$];
  int         nfr = 0;
  int         tend = 0;
  int         cyc = 0;
  initial rxd = 1'b1;
  always @(posedge aclk) cyc <= cyc + 1;
  // start, 8 bits lsb first, stop, idle high
  task automatic send(input logic [7:0] b);
    logic [9:0] w;
    w = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= w[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask
  // mid-bit samples on the falling edge, clear of the launch edge
  initial begin : rx
    logic [7:0] b;
    int         idle;
    idle = 0;
    forever begin
      @(negedge aclk);
      idle++;
      if (txd === 1'b0) begin
        repeat (BIT / 2) @(negedge aclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(negedge aclk);
          b[i] = txd;
        end
        repeat (BIT) @(negedge aclk);
        // a long quiet line starts a new frame
        if (idle > 3 * BIT) q.delete();
        q.push_back(b);
        idle = 0;
        if (q.size() == 9) begin
          nfr++;
          tend = cyc;
        end
      end
    end
  end
endmodule // host_link

// ==== testbench/tb_top.sv ====
// self-checking bench of the gas module serial framer
`timescale 1ns/10ps
module tb_top;
  import gas_framer_pkg::*;
  typedef struct {logic [15:0] s; logic [7:0] h, l;} row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rxd, txd, led, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  f[9];
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n, t0;
  row_t        rows[3] = '{'{16'h0000, 8'h00, 8'h00},
    '{16'h8123, 8'h81, 8'h23}, '{16'h7f12, 8'h7f, 8'h12}};
  // shortened timing keeps the run short; only each blink pattern's on to off ratio follows the rules
  localparam int          BIT_N  = 16;
  localparam logic [31:0] UP_T   = 32'h7d0;
  localparam logic [31:0] QA_T   = 32'h1388;
  localparam logic [35:0] PRE_T  = 36'hbb8;
  localparam logic [31:0] SLOW_T = 32'h28;
  localparam logic [31:0] F_ON   = 32'hf;
  localparam logic [31:0] F_OFF  = 32'h23;
  localparam logic [31:0] A_ON   = 32'ha;
  localparam logic [31:0] A_OFF  = 32'h1e;
  gas_module_serial_framer #(
    .BIT_CYC(16'(BIT_N)), .UPLOAD_LEN(UP_T), .QA_LEN(QA_T),
    .PREHEAT_LEN(PRE_T), .SLOW_ON_LEN(SLOW_T), .SLOW_OFF_LEN(SLOW_T),
    .FAULT_ON_LEN(F_ON), .FAULT_OFF_LEN(F_OFF), .ALARM_ON_LEN(A_ON),
    .ALARM_OFF_LEN(A_OFF)
  ) gas_module_serial_framer_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd),
    .led(led), .irq(irq)
  );
  host_link #(.BIT(BIT_N)) host_link_i (.aclk(aclk), .txd(txd), .rxd(rxd));
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // ready is read at the falling edge, so the take needs no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, dn;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      dn = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, dn;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      ta = arvalid & arready;
      dn = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic get_frame(input int n0);
    for (int t = 0; t < 4000 && host_link_i.nfr == n0; t++) @(posedge aclk);
    foreach (f[i]) f[i] = host_link_i.q[i];
  endtask
  task automatic cmp_frame(input logic [7:0] b1, b2, b3, b4, b5, b6, b7);
    logic [7:0] e[9];
    logic [7:0] s;
    e = '{8'hff, b1, b2, b3, b4, b5, b6, b7, 8'h00};
    s = 8'h00;
    for (int i = 1; i < 8; i++) s -= e[i];
    e[8] = s;
    foreach (e[i]) check("frame byte", e[i], f[i]);
  endtask
  // one full lit and dark phase, skipping any partial one
  task automatic blink(input int on, input int off);
    int t, h, l;
    @(negedge aclk);
    for (t = 0; t < 300 && led !== 1'b0; t++) @(negedge aclk);
    for (t = 0; t < 200 && led !== 1'b1; t++) @(negedge aclk);
    for (h = 0; h < 300 && led === 1'b1; h++) @(negedge aclk);
    for (l = 0; l < 300 && led === 1'b0; l++) @(negedge aclk);
    check("led lit", on, h);
    check("led dark", off, l);
    @(posedge aclk);
  endtask
  task automatic query(input logic [7:0] sum);
    logic [7:0] b[9];
    b = '{8'hff, 8'h01, 8'h86, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, sum};
    foreach (b[i]) host_link_i.send(b[i]);
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("txd idle", 1, txd);
    check("led", 0, led);
    blink(40, 40);
    rd(SENSOR_OFS);
    check("sensor rst", 0, rv);
    rd(8'h10);
    check("rd decerr", 3, rs);
    wr(8'h10, 32'h1);
    check("wr decerr", 3, rs);
    foreach (rows[i]) begin
      wr(SENSOR_OFS, {16'h0, rows[i].s});
      get_frame(host_link_i.nfr);
      n = host_link_i.nfr;
      t0 = host_link_i.tend;
      get_frame(n);
      check("period", 2000, host_link_i.tend - t0);
      cmp_frame(8'h01, 8'h03, 8'h00, rows[i].h, rows[i].l, 8'h13, 8'h88);
    end
    wr(SENSOR_OFS, 32'h0);
    blink(0, 300);
    wr(SENSOR_OFS, 32'h8000);
    blink(15, 35);
    wr(SENSOR_OFS, 32'hc000);
    blink(15, 35);
    wr(SENSOR_OFS, 32'h4000);
    blink(10, 30);
    wr(SENSOR_OFS, 32'hc123);
    wr(IRQ_MASK_OFS, 32'h8);
    get_frame(host_link_i.nfr);
    // query ends after the next upload, before the one after it
    repeat (800) @(posedge aclk);
    query(8'h79);
    n = host_link_i.nfr;
    get_frame(n);
    cmp_frame(8'h86, 8'h81, 8'h23, 8'h00, 8'h00, 8'h81, 8'h23);
    rd(IRQ_STAT_OFS);
    check("query seen", 1, rv[1]);
    wr(IRQ_STAT_OFS, 32'hf);
    query(8'h78);
    n = host_link_i.nfr;
    rd(IRQ_STAT_OFS);
    check("dropped", 1, rv[2]);
    @(negedge aclk);
    check("irq masked", 0, irq);
    repeat (1500) @(posedge aclk);
    check("no upload", n, host_link_i.nfr);
    rd(STATUS_OFS);
    check("answer mode", 1, rv[0]);
    for (int t = 0; t < 1500 && irq !== 1'b1; t++) @(posedge aclk);
    check("revert irq", 1, irq);
    rd(STATUS_OFS);
    check("upload mode", 0, rv[0]);
    wr(IRQ_STAT_OFS, 32'h8);
    @(negedge aclk);
    check("irq clear", 0, irq);
    get_frame(host_link_i.nfr);
    cmp_frame(8'h01, 8'h03, 8'h00, 8'hc1, 8'h23, 8'h13, 8'h88);
    give_verdict();
  end
endmodule // tb_top
